/* File: irq_ctrl_pkg.sv */
// Shared constants and carrier types for the interrupt control block
`default_nettype none
package irq_ctrl_pkg;

	// ----------------------------------------------------------------
	// Source counts and ranks
	// ----------------------------------------------------------------
	localparam int unsigned NUM_SRC        = 12;
	localparam int unsigned NUM_PIN        = 2;
	localparam int unsigned RANK_WDT       = 0;
	localparam int unsigned RANK_PIN0      = 1;
	localparam int unsigned RANK_PIN1      = 2;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_REQ_LOW   = 16'hFFE0;
	localparam logic [15:0] ADDR_REQ_HIGH  = 16'hFFE1;
	localparam logic [15:0] ADDR_MASK_LOW  = 16'hFFE4;
	localparam logic [15:0] ADDR_MASK_HIGH = 16'hFFE5;
	localparam logic [15:0] ADDR_LVL_LOW   = 16'hFFE8;
	localparam logic [15:0] ADDR_LVL_HIGH  = 16'hFFE9;
	localparam logic [15:0] ADDR_RISE_EN   = 16'hFF48;
	localparam logic [15:0] ADDR_FALL_EN   = 16'hFF49;
	localparam logic [15:0] ADDR_STATUS    = 16'hFF1E;

	// ----------------------------------------------------------------
	// Reset values and field layout
	// ----------------------------------------------------------------
	localparam logic [15:0] REQ_RESET      = 16'h0000;
	localparam logic [15:0] MASK_RESET     = 16'hFFFF;
	localparam logic [15:0] LVL_RESET      = 16'hFFFF;
	localparam logic [7:0]  EDGE_RESET     = 8'h00;
	localparam logic [7:0]  STATUS_RESET   = 8'h02;
	localparam logic [7:0]  EDGE_USED      = 8'h03;
	localparam logic [15:0] MASK_UNDEF_VAL = 16'hFFFF;
	localparam int unsigned STATUS_IE_BIT  = 7;
	localparam int unsigned STATUS_ISP_BIT = 1;

	// ----------------------------------------------------------------
	// Vector table
	// ----------------------------------------------------------------
	localparam logic [15:0] VEC_NMI        = 16'h0004;
	localparam logic [15:0] VEC_BASE       = 16'h0004;
	localparam logic [15:0] VEC_STEP       = 16'h0002;
	localparam logic [15:0] VEC_TRAP       = 16'h003E;

	// Register access from the core
	typedef struct packed {
		logic        wr;     // Write strobe
		logic        rd;     // Read strobe
		logic [15:0] addr;   // Byte address, even for word access
		logic        word;   // Combined 16-bit access
		logic [7:0]  bmask;  // Bit lanes touched, all ones for byte access
		logic [15:0] wdata;  // Write data, high byte for word access
	} sfr_req_t;

	// Pending interrupt offered to the core
	typedef struct packed {
		logic        valid;  // Something is acceptable now
		logic        nmi;    // It is the non-maskable request
		logic [3:0]  rank;   // Maskable source rank
		logic [15:0] vector; // Vector table address
	} irq_offer_t;

endpackage

`default_nettype wire

/* File: pin_edge_detect.sv */
// Synchroniser and selectable edge detector for one external interrupt pin
`timescale 1ns/1ns
`default_nettype none

module pin_edge_detect (
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic pin_i,
	input  wire logic rise_en_i,
	input  wire logic fall_en_i,
	output logic      edge_o
);

	logic sync_first;
	logic sync_second;
	logic sample_prev;

	// ----------------------------------------------------------------
	// Synchronise and keep previous sample
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sync_first  <= 1'b0;
			sync_second <= 1'b0;
			sample_prev <= 1'b0;
		end else begin
			sync_first  <= pin_i;
			sync_second <= sync_first;
			sample_prev <= sync_second;
		end
	end

	// Edge selection, both enables low disables detection
	always_comb begin
		edge_o = (rise_en_i & sync_second & ~sample_prev) |
		         (fall_en_i & ~sync_second & sample_prev);
	end

endmodule

`default_nettype wire

/* File: irq_ctrl.sv */
// Interrupt request, mask, level and status word control for the core
//
// What this block does
// - Acknowledge clears that source's request flag
// - Set mask bit blocks service and wake
// - Mask pair byte/bit/word writable, resets ones
// - Level pair byte/bit/word writable, resets ones
// - Watchdog flag accessible only in interval mode
// - Mask read undefined in watchdog mode one
// - Output-mode pin change sets pin request flag
// - Rise/fall enable pair selects valid edge
// - Edge enables at FF48/FF49, two bits, reset zero
// - Status word: enable and level, byte/bit/instructions
// - Vectored ack or trap saves status, clears enable
// - Maskable ack copies level bit to in-service
// - Status pushed by push, restored by returns/pop
// - Reset loads status word with 02H
// - Non-maskable ignores enable, outranks all others
// - Non-maskable ack saves status, clears both flags
// - Repeat non-maskable waits return plus one instruction
// - Several repeats collapse into one request
// - Equal levels resolve by fixed rank, zero first
// - Eligible when flag set, mask clear, enable set
// - High-level requests win before rank applies
// - In-service flag zero while serving high level or non-maskable
`timescale 1ns/1ns
`default_nettype none

module irq_ctrl (
	input  wire logic                     clk_i,
	input  wire logic                     srst_i,
	input  wire irq_ctrl_pkg::sfr_req_t   sfr_i,
	output logic [15:0]                   sfr_rdata_o,
	input  wire logic [1:0]               ext_pin_i,
	input  wire logic [11:0]              src_event_i,
	input  wire logic                     wdt_overflow_i,
	input  wire logic                     wdt_mode_one_i,
	output irq_ctrl_pkg::irq_offer_t      offer_o,
	input  wire logic                     ack_i,
	input  wire logic                     trap_i,
	input  wire logic                     unmask_all_i,
	input  wire logic                     mask_all_i,
	input  wire logic                     status_push_i,
	input  wire logic                     status_pop_i,
	input  wire logic                     return_irq_i,
	input  wire logic                     return_trap_i,
	input  wire logic [7:0]               stack_data_i,
	input  wire logic                     instr_done_i,
	output logic [7:0]                    status_save_o,
	output logic [7:0]                    status_o,
	output logic                          wake_o
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [15:0] request_word;
	logic [15:0] mask_word;
	logic [15:0] level_word;
	logic [7:0]  rise_edge_enable_reg;
	logic [7:0]  fall_edge_enable_reg;
	logic [7:0]  status_word;
	logic        nmi_pending;
	logic        nmi_in_service;
	logic        nmi_hold;

	logic [1:0]  pin_edge;
	logic [15:0] hw_set;
	logic [15:0] ack_clear;
	logic [15:0] eligible;
	logic [15:0] high_elig;
	logic [3:0]  pick_rank;
	logic        pick_any;
	logic        pick_high;
	logic        mask_accept;
	logic        nmi_accept;
	logic [15:0] vec_offset;

	// Write lane masks per byte of each 16-bit register
	logic        wr_low_req;
	logic        wr_high_req;
	logic        wr_low_mask;
	logic        wr_high_mask;
	logic        wr_low_lvl;
	logic        wr_high_lvl;
	logic [7:0]  wdata_low;
	logic [7:0]  wdata_high;
	logic [15:0] wr_lanes_req;
	logic [15:0] wr_lanes_mask;
	logic [15:0] wr_lanes_lvl;
	logic [15:0] wr_data16;

	// ----------------------------------------------------------------
	// External pin edge detection
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < irq_ctrl_pkg::NUM_PIN; gi++) begin : g_pin
			pin_edge_detect u_edge (
				.clk_i     (clk_i),
				.srst_i    (srst_i),
				.pin_i     (ext_pin_i[gi]),
				.rise_en_i (rise_edge_enable_reg[gi]),
				.fall_en_i (fall_edge_enable_reg[gi]),
				.edge_o    (pin_edge[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Register write decode
	// ----------------------------------------------------------------
	// Word access carries low byte in wdata[7:0] and high byte above
	always_comb begin
		wdata_low    = sfr_i.wdata[7:0];
		wdata_high   = sfr_i.word ? sfr_i.wdata[15:8] : sfr_i.wdata[7:0];
		wr_low_req   = 1'b0;
		wr_high_req  = 1'b0;
		wr_low_mask  = 1'b0;
		wr_high_mask = 1'b0;
		wr_low_lvl   = 1'b0;
		wr_high_lvl  = 1'b0;
		if (sfr_i.wr) begin
			if (sfr_i.addr == irq_ctrl_pkg::ADDR_REQ_LOW) begin
				wr_low_req  = 1'b1;
				wr_high_req = sfr_i.word;
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_REQ_HIGH) begin
				wr_high_req = ~sfr_i.word;
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_MASK_LOW) begin
				wr_low_mask  = 1'b1;
				wr_high_mask = sfr_i.word;
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_MASK_HIGH) begin
				wr_high_mask = ~sfr_i.word;
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_LVL_LOW) begin
				wr_low_lvl  = 1'b1;
				wr_high_lvl = sfr_i.word;
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_LVL_HIGH) begin
				wr_high_lvl = ~sfr_i.word;
			end
		end
		wr_data16     = {wdata_high, wdata_low};
		wr_lanes_req  = {wr_high_req ? sfr_i.bmask : 8'h00,
		                 wr_low_req ? sfr_i.bmask : 8'h00};
		wr_lanes_mask = {wr_high_mask ? sfr_i.bmask : 8'h00,
		                 wr_low_mask ? sfr_i.bmask : 8'h00};
		wr_lanes_lvl  = {wr_high_lvl ? sfr_i.bmask : 8'h00,
		                 wr_low_lvl ? sfr_i.bmask : 8'h00};
		// Watchdog flag is not software-writable in watchdog mode one
		if (wdt_mode_one_i) begin
			wr_lanes_req[irq_ctrl_pkg::RANK_WDT] = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Priority selection among maskable requests
	// ----------------------------------------------------------------
	always_comb begin
		hw_set = {4'h0, src_event_i};
		hw_set[irq_ctrl_pkg::RANK_WDT]  = wdt_overflow_i & ~wdt_mode_one_i;
		hw_set[irq_ctrl_pkg::RANK_PIN0] = pin_edge[0];
		hw_set[irq_ctrl_pkg::RANK_PIN1] = pin_edge[1];
		eligible  = request_word & ~mask_word;
		eligible[15:irq_ctrl_pkg::NUM_SRC] = 4'h0;
		high_elig = eligible & ~level_word;
		pick_high = |high_elig;
		pick_any  = |eligible;
		pick_rank = 4'h0;
		// Lowest rank wins within the chosen level group
		for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (pick_high ? high_elig[i] : eligible[i]) begin
				pick_rank = 4'(i);
			end
		end
		mask_accept = pick_any & status_word[irq_ctrl_pkg::STATUS_IE_BIT] &
		              (status_word[irq_ctrl_pkg::STATUS_ISP_BIT] | pick_high);
		nmi_accept  = nmi_pending & ~nmi_in_service & ~nmi_hold;
		vec_offset  = {12'h000, pick_rank} * irq_ctrl_pkg::VEC_STEP;
	end

	// Offer to the core, non-maskable first and independent of enable
	always_comb begin
		offer_o.valid  = nmi_accept | mask_accept;
		offer_o.nmi    = nmi_accept;
		offer_o.rank   = pick_rank;
		offer_o.vector = nmi_accept ? irq_ctrl_pkg::VEC_NMI :
		                 16'(irq_ctrl_pkg::VEC_BASE + vec_offset);
		// Maskable wake needs an unmasked request only
		wake_o         = pick_any | nmi_pending;
	end

	// Clear of the acknowledged maskable flag
	always_comb begin
		ack_clear = 16'h0000;
		if (ack_i && !nmi_accept && mask_accept) begin
			ack_clear[pick_rank] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Request flags, hardware set wins over any clear
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			request_word <= irq_ctrl_pkg::REQ_RESET;
		end else begin
			request_word <= (((request_word & ~wr_lanes_req) |
			                  (wr_data16 & wr_lanes_req)) & ~ack_clear) | hw_set;
		end
	end

	// Mask and level pairs
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			mask_word  <= irq_ctrl_pkg::MASK_RESET;
			level_word <= irq_ctrl_pkg::LVL_RESET;
		end else begin
			mask_word  <= (mask_word & ~wr_lanes_mask) | (wr_data16 & wr_lanes_mask);
			level_word <= (level_word & ~wr_lanes_lvl) | (wr_data16 & wr_lanes_lvl);
		end
	end

	// Edge enable registers, only pin bits are stored
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rise_edge_enable_reg <= irq_ctrl_pkg::EDGE_RESET;
			fall_edge_enable_reg <= irq_ctrl_pkg::EDGE_RESET;
		end else if (sfr_i.wr && !sfr_i.word) begin
			if (sfr_i.addr == irq_ctrl_pkg::ADDR_RISE_EN) begin
				rise_edge_enable_reg <= ((rise_edge_enable_reg & ~sfr_i.bmask) |
				                        (wdata_low & sfr_i.bmask)) & irq_ctrl_pkg::EDGE_USED;
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_FALL_EN) begin
				fall_edge_enable_reg <= ((fall_edge_enable_reg & ~sfr_i.bmask) |
				                        (wdata_low & sfr_i.bmask)) & irq_ctrl_pkg::EDGE_USED;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status word
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			status_word <= irq_ctrl_pkg::STATUS_RESET;
		end else if (ack_i && nmi_accept) begin
			status_word[irq_ctrl_pkg::STATUS_IE_BIT]  <= 1'b0;
			status_word[irq_ctrl_pkg::STATUS_ISP_BIT] <= 1'b0;
		end else if (ack_i && mask_accept) begin
			status_word[irq_ctrl_pkg::STATUS_IE_BIT]  <= 1'b0;
			status_word[irq_ctrl_pkg::STATUS_ISP_BIT] <= level_word[pick_rank];
		end else if (trap_i) begin
			status_word[irq_ctrl_pkg::STATUS_IE_BIT] <= 1'b0;
		end else if (status_pop_i || return_irq_i || return_trap_i) begin
			status_word <= stack_data_i;
		end else if (unmask_all_i) begin
			status_word[irq_ctrl_pkg::STATUS_IE_BIT] <= 1'b1;
		end else if (mask_all_i) begin
			status_word[irq_ctrl_pkg::STATUS_IE_BIT] <= 1'b0;
		end else if (sfr_i.wr && !sfr_i.word && sfr_i.addr == irq_ctrl_pkg::ADDR_STATUS) begin
			status_word <= (status_word & ~sfr_i.bmask) | (wdata_low & sfr_i.bmask);
		end
	end

	// Copy presented for the core to push on the stack
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			status_save_o <= irq_ctrl_pkg::STATUS_RESET;
		end else if ((ack_i && offer_o.valid) || trap_i || status_push_i) begin
			status_save_o <= status_word;
		end
	end

	// ----------------------------------------------------------------
	// Non-maskable request tracking
	// ----------------------------------------------------------------
	// One pending bit, so repeats during service merge into one
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			nmi_pending <= 1'b0;
		end else if (wdt_overflow_i && wdt_mode_one_i) begin
			nmi_pending <= 1'b1;
		end else if (ack_i && nmi_accept) begin
			nmi_pending <= 1'b0;
		end
	end

	// Service state, and a hold for one main instruction after return
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			nmi_in_service <= 1'b0;
			nmi_hold       <= 1'b0;
		end else if (ack_i && nmi_accept) begin
			nmi_in_service <= 1'b1;
			nmi_hold       <= 1'b0;
		end else if (return_irq_i && nmi_in_service) begin
			nmi_in_service <= 1'b0;
			nmi_hold       <= 1'b1;
		end else if (instr_done_i) begin
			nmi_hold       <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sfr_rdata_o <= 16'h0000;
		end else if (sfr_i.rd) begin
			if (sfr_i.addr == irq_ctrl_pkg::ADDR_REQ_LOW) begin
				sfr_rdata_o <= sfr_i.word ? request_word : {8'h00, request_word[7:0]};
				if (wdt_mode_one_i) begin
					sfr_rdata_o[irq_ctrl_pkg::RANK_WDT] <= 1'b0;
				end
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_REQ_HIGH) begin
				sfr_rdata_o <= {8'h00, request_word[15:8]};
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_MASK_LOW) begin
				if (wdt_mode_one_i) begin
					sfr_rdata_o <= irq_ctrl_pkg::MASK_UNDEF_VAL;
				end else begin
					sfr_rdata_o <= sfr_i.word ? mask_word : {8'h00, mask_word[7:0]};
				end
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_MASK_HIGH) begin
				sfr_rdata_o <= {8'h00, mask_word[15:8]};
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_LVL_LOW) begin
				sfr_rdata_o <= sfr_i.word ? level_word : {8'h00, level_word[7:0]};
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_LVL_HIGH) begin
				sfr_rdata_o <= {8'h00, level_word[15:8]};
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_RISE_EN) begin
				sfr_rdata_o <= {8'h00, rise_edge_enable_reg};
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_FALL_EN) begin
				sfr_rdata_o <= {8'h00, fall_edge_enable_reg};
			end else if (sfr_i.addr == irq_ctrl_pkg::ADDR_STATUS) begin
				sfr_rdata_o <= {8'h00, status_word};
			end else begin
				sfr_rdata_o <= 16'h0000;
			end
		end
	end

	// Live status word for the core; level bit reads one after reset
	always_comb begin
		status_o = status_word;
	end

endmodule

`default_nettype wire

/* File: irq_ctrl_chk.sv */
// Concurrent checks on the interrupt control block ports
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_chk (
	input  wire logic                     clk_i,
	input  wire logic                     srst_i,
	input  wire irq_ctrl_pkg::sfr_req_t   sfr_i,
	input  wire logic [15:0]              sfr_rdata_o,
	input  wire irq_ctrl_pkg::irq_offer_t offer_o,
	input  wire logic                     ack_i,
	input  wire logic                     trap_i,
	input  wire logic                     unmask_all_i,
	input  wire logic                     mask_all_i,
	input  wire logic                     status_push_i,
	input  wire logic                     status_pop_i,
	input  wire logic                     return_irq_i,
	input  wire logic                     return_trap_i,
	input  wire logic [7:0]               stack_data_i,
	input  wire logic                     instr_done_i,
	input  wire logic [7:0]               status_save_o,
	input  wire logic [7:0]               status_o,
	input  wire logic                     wake_o
);
	logic take;
	logic busy;
	logic nmi_svc;
	logic nmi_gap;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	// Offer taken, and status updates that outrank the enable instructions
	assign take = ack_i && offer_o.valid;
	assign busy = take || trap_i || status_pop_i || return_irq_i || return_trap_i;

	// Non-maskable service and the gap up to the next main instruction
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			nmi_svc <= 1'b0;
			nmi_gap <= 1'b0;
		end else begin
			if (take && offer_o.nmi) begin
				nmi_svc <= 1'b1;
			end else if (return_irq_i) begin
				nmi_svc <= 1'b0;
			end
			if (nmi_svc && return_irq_i) begin
				nmi_gap <= 1'b1;
			end else if (instr_done_i) begin
				nmi_gap <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequences and assertions
	// ----------------------------------------------------------------
	sequence nmi_take_s;
		take && offer_o.nmi;
	endsequence
	sequence mask_offer_s;
		offer_o.valid && !offer_o.nmi;
	endsequence

	reset_status_a: assert property ($fell(srst_i) |-> status_o == 8'h02)
		else $error("status word wrong after reset");
	ack_enable_a: assert property (take |=> !status_o[7])
		else $error("enable flag not cleared by acknowledge");
	nmi_flags_a: assert property (nmi_take_s |=> !status_o[7] && !status_o[1])
		else $error("non-maskable acknowledge left a flag set");
	nmi_hold_a: assert property ((nmi_svc || nmi_gap) |-> !(offer_o.valid && offer_o.nmi))
		else $error("non-maskable offered too early");
	offer_enable_a: assert property (mask_offer_s |-> status_o[7] && wake_o)
		else $error("maskable offer without enable or wake");
	vector_map_a: assert property (offer_o.valid |-> offer_o.vector == (offer_o.nmi ?
		16'h0004 : 16'h0004 + {11'h000, offer_o.rank, 1'b0}))
		else $error("offer vector wrong");
	push_save_a: assert property (status_push_i && !take && !trap_i |=>
		status_save_o == $past(status_o))
		else $error("pushed status word wrong");
	pop_restore_a: assert property ((status_pop_i || return_irq_i || return_trap_i) &&
		!take && !trap_i |=> status_o == $past(stack_data_i))
		else $error("status word not restored");
	enable_set_a: assert property (unmask_all_i && !busy |=> status_o[7])
		else $error("enable instruction ignored");
	enable_clear_a: assert property (mask_all_i && !busy && !unmask_all_i |=> !status_o[7])
		else $error("disable instruction ignored");
	rdata_hold_a: assert property (!sfr_i.rd |=> $stable(sfr_rdata_o))
		else $error("read data moved without a read");
endmodule

bind irq_ctrl irq_ctrl_chk u_irq_ctrl_chk (.clk_i, .srst_i, .sfr_i, .sfr_rdata_o, .offer_o,
	.ack_i, .trap_i, .unmask_all_i, .mask_all_i, .status_push_i, .status_pop_i, .return_irq_i,
	.return_trap_i, .stack_data_i, .instr_done_i, .status_save_o, .status_o, .wake_o);
`default_nettype wire

/* File: core_model.sv */
// Behavioural core that accepts offered interrupts after a set delay
`timescale 1ns/1ns
`default_nettype none
module core_model (
	input  wire logic                     clk_i,
	input  wire logic                     srst_i,
	input  wire irq_ctrl_pkg::irq_offer_t offer_i,
	input  wire logic                     take_i,
	input  wire logic [3:0]               delay_i,
	output logic                          ack_o,
	output logic [15:0]                   vec_o
);
	logic [3:0] wait_cnt;

	// Acknowledge pulse once the offer has stood for the delay
	always_ff @(posedge clk_i) begin
		if (srst_i || !offer_i.valid || ack_o) begin
			wait_cnt <= 4'h0;
			ack_o <= 1'b0;
		end else if (take_i && wait_cnt >= delay_i) begin
			ack_o <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end

	// Program counter loaded from the offered vector
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			vec_o <= 16'h0000;
		end else if (ack_o && offer_i.valid) begin
			vec_o <= offer_i.vector;
		end
	end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Directed testbench for the interrupt control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic                     clk;
	logic                     srst;
	irq_ctrl_pkg::sfr_req_t   sfr;
	logic [15:0]              rdata;
	logic [1:0]               pins;
	logic [11:0]              src;
	logic [8:0]               ctl;
	logic                     mode1;
	irq_ctrl_pkg::irq_offer_t offer;
	logic                     ack;
	logic [7:0]               stack;
	logic [7:0]               save;
	logic [7:0]               status;
	logic                     wake;
	logic                     take;
	logic [3:0]               dly;
	logic [15:0]              vec;
	int                       fail_count;
	int                       comparisons;

	// Clock and instances
	initial clk = 1'b0;
	always #10 clk = ~clk;
	irq_ctrl u_irq_ctrl (.clk_i(clk), .srst_i(srst), .sfr_i(sfr), .sfr_rdata_o(rdata),
		.ext_pin_i(pins), .src_event_i(src), .wdt_overflow_i(ctl[8]), .wdt_mode_one_i(mode1),
		.offer_o(offer), .ack_i(ack), .trap_i(ctl[0]), .unmask_all_i(ctl[1]),
		.mask_all_i(ctl[2]), .status_push_i(ctl[3]), .status_pop_i(ctl[4]),
		.return_irq_i(ctl[5]), .return_trap_i(ctl[6]), .stack_data_i(stack),
		.instr_done_i(ctl[7]), .status_save_o(save), .status_o(status), .wake_o(wake));
	core_model u_core_model (.clk_i(clk), .srst_i(srst), .offer_i(offer), .take_i(take),
		.delay_i(dly), .ack_o(ack), .vec_o(vec));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task acc(input logic w, input logic [15:0] a, input logic wd, input logic [7:0] bm,
		input logic [15:0] d);
		@(negedge clk);
		sfr = '{w, !w, a, wd, bm, d};
		@(negedge clk);
		sfr = '0;
	endtask
	task rd(input logic [15:0] a, input logic wd, input logic [15:0] exp);
		acc(1'b0, a, wd, 8'hFF, 16'h0000);
		chk(rdata, exp);
	endtask
	// Control pulse: 0 trap 1 en 2 dis 3 push 4 pop 5 return_from_interrupt 6 return_from_trap 7 instr 8 wdt
	task pulse(input logic [8:0] b, input logic [11:0] s);
		@(negedge clk);
		ctl = b;
		src = s;
		@(negedge clk);
		ctl = '0;
		src = '0;
	endtask
	task take_irq(input logic [15:0] v);
		int n;
		take = 1'b1;
		n = 0;
		while (ack !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		take = 1'b0;
		if (n >= 50) begin
			fail_count++;
			$display("ERROR %0t: no acknowledge", $time);
			complete_run();
		end else begin
			@(negedge clk);
			chk(vec, v);
		end
	endtask
	task complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		sfr = '0;
		pins = 2'b00;
		src = '0;
		ctl = '0;
		mode1 = 1'b0;
		stack = 8'h00;
		take = 1'b0;
		dly = 4'h3;
		fail_count = 0;
		comparisons = 0;
		srst = 1'b1;
		repeat (6) @(negedge clk);
		srst = 1'b0;
		rd(16'hFFE4, 1'b1, 16'hFFFF);
		rd(16'hFFE8, 1'b1, 16'hFFFF);
		rd(16'hFF48, 1'b0, 16'h0000);
		rd(16'hFF49, 1'b0, 16'h0000);
		rd(16'hFF1E, 1'b0, 16'h0002);
		rd(16'hFF00, 1'b0, 16'h0000);
		$display("Test reset values done");
		acc(1'b1, 16'hFFE4, 1'b1, 8'hFF, 16'hF5A0);
		acc(1'b1, 16'hFFE4, 1'b0, 8'h01, 16'h0001);
		acc(1'b1, 16'hFFE5, 1'b0, 8'hFF, 16'h00F3);
		rd(16'hFFE4, 1'b1, 16'hF3A1);
		acc(1'b1, 16'hFFE8, 1'b1, 8'hFF, 16'hFDFF);
		rd(16'hFFE8, 1'b1, 16'hFDFF);
		acc(1'b1, 16'hFF48, 1'b0, 8'hFF, 16'h00FF);
		rd(16'hFF48, 1'b0, 16'h0003);
		$display("Test register access done");
		for (int m = 0; m < 4; m++) begin
			acc(1'b1, 16'hFF48, 1'b0, 8'hFF, {14'h0, m[1], m[1]});
			acc(1'b1, 16'hFF49, 1'b0, 8'hFF, {14'h0, m[0], m[0]});
			acc(1'b1, 16'hFFE0, 1'b1, 8'hFF, 16'h0000);
			pins = 2'b11;
			repeat (6) @(negedge clk);
			rd(16'hFFE0, 1'b1, {13'h0, m[1], m[1], 1'b0});
			acc(1'b1, 16'hFFE0, 1'b1, 8'hFF, 16'h0000);
			pins = 2'b00;
			repeat (6) @(negedge clk);
			rd(16'hFFE0, 1'b1, {13'h0, m[0], m[0], 1'b0});
		end
		acc(1'b1, 16'hFFE0, 1'b1, 8'hFF, 16'h0000);
		$display("Test edge selection done");
		acc(1'b1, 16'hFFE4, 1'b1, 8'hFF, 16'hF000);
		pulse(9'h000, 12'h2A0);
		chk({15'h0, offer.valid}, 16'h0000);
		pulse(9'h002, 12'h000);
		chk({12'h000, offer.rank}, 16'h0009);
		take_irq(16'h0016);
		chk({8'h00, status}, 16'h0000);
		chk({8'h00, save}, 16'h0082);
		rd(16'hFFE0, 1'b1, 16'h00A0);
		pulse(9'h002, 12'h000);
		chk({15'h0, offer.valid}, 16'h0000);
		stack = 8'h82;
		pulse(9'h020, 12'h000);
		dly = 4'h0;
		take_irq(16'h000E);
		chk({8'h00, status}, 16'h0002);
		stack = 8'h02;
		pulse(9'h020, 12'h000);
		$display("Test maskable priority done");
		mode1 = 1'b1;
		rd(16'hFFE4, 1'b1, 16'hFFFF);
		acc(1'b1, 16'hFFE4, 1'b1, 8'hFF, 16'hFFFF);
		acc(1'b1, 16'hFFE8, 1'b0, 8'h01, 16'h0001);
		acc(1'b1, 16'hFFE0, 1'b1, 8'hFF, 16'h0001);
		rd(16'hFFE0, 1'b1, 16'h0000);
		pulse(9'h100, 12'h000);
		chk({14'h0, offer.valid, offer.nmi}, 16'h0003);
		take_irq(16'h0004);
		chk({8'h00, status}, 16'h0000);
		pulse(9'h100, 12'h000);
		pulse(9'h100, 12'h000);
		chk({15'h0, offer.valid}, 16'h0000);
		pulse(9'h020, 12'h000);
		chk({15'h0, offer.valid}, 16'h0000);
		pulse(9'h080, 12'h000);
		take_irq(16'h0004);
		pulse(9'h020, 12'h000);
		pulse(9'h080, 12'h000);
		chk({15'h0, offer.valid}, 16'h0000);
		mode1 = 1'b0;
		$display("Test non-maskable done");
		pulse(9'h008, 12'h000);
		chk({8'h00, save}, 16'h0002);
		acc(1'b1, 16'hFF1E, 1'b0, 8'hFF, 16'h0082);
		chk({8'h00, status}, 16'h0082);
		acc(1'b1, 16'hFF1E, 1'b0, 8'h80, 16'h0000);
		chk({8'h00, status}, 16'h0002);
		pulse(9'h002, 12'h000);
		pulse(9'h001, 12'h000);
		chk({8'h00, status}, 16'h0002);
		chk({8'h00, save}, 16'h0082);
		stack = 8'h82;
		pulse(9'h040, 12'h000);
		chk({8'h00, status}, 16'h0082);
		pulse(9'h004, 12'h000);
		chk({8'h00, status}, 16'h0002);
		stack = 8'h80;
		pulse(9'h010, 12'h000);
		chk({8'h00, status}, 16'h0080);
		$display("Test status word done");
		pulse(9'h000, 12'h010);
		chk({15'h0, wake}, 16'h0000);
		acc(1'b1, 16'hFFE4, 1'b0, 8'h10, 16'h0000);
		chk({15'h0, wake}, 16'h0001);
		$display("Test standby release done");
		complete_run();
	end
endmodule
`default_nettype wire
